// >>> cled_pkg.sv
// LED decoder constants, register map and mode type
package cled_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_HZ = 200_000_000;
    // blink rates in millihertz
    localparam longint unsigned FAST_BLINK_MHZ = 64'd2000;
    localparam longint unsigned SLOW_BLINK_MHZ = 64'd500;
    // fast half period in clock cycles, rounded down
    localparam longint unsigned FAST_HALF_CYC_L =
        (64'(CLK_HZ) * 64'd1000) / (FAST_BLINK_MHZ * 64'd2);
    localparam int FAST_HALF_CYC = int'(FAST_HALF_CYC_L);
    // fast half periods in one slow half period
    localparam int SLOW_PER_FAST = int'(FAST_BLINK_MHZ / SLOW_BLINK_MHZ);

    ////////////////////////////////////////////////////////////////////////////
    // channel counts
    localparam int N_IN_CH = 8;
    localparam int N_OUT_CH = 3;

    ////////////////////////////////////////////////////////////////////////////
    // register map (byte addresses)
    localparam int ADR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] IN_ACT_OFS = 8'h04;
    localparam logic [7:0] OUT_ACT_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
    localparam logic [7:0] LED_IN_OFS = 8'h18;
    localparam logic [7:0] LED_OUT_OFS = 8'h1C;

    // field positions
    localparam int CTRL_CFG_BIT = 0;
    localparam int STAT_FAST_BIT = 4;
    localparam int STAT_SLOW_BIT = 5;
    localparam int LED_OUT_STAT_POS = 8;
    localparam int LED_OUT_MISC_POS = 16;

    // interrupt event bits
    localparam int EV_MOD_FAULT = 0;
    localparam int EV_REINT = 1;
    localparam int EV_SUPPLY = 2;
    localparam int EV_SAFETY = 3;
    localparam int EV_W = 4;

    // reset values
    localparam logic CTRL_CFG_RST = 1'b0;
    localparam logic [7:0] ACT_RST = 8'h00;
    localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // display modes, highest priority first
    typedef enum logic [3:0] {
        CLED_OFF        = 4'h0,
        CLED_FW_UPDATE  = 4'h1,
        CLED_MOD_FAULT  = 4'h2,
        CLED_REV_MISM   = 4'h3,
        CLED_IDENT      = 4'h4,
        CLED_ADDR_MISM  = 4'h5,
        CLED_UNCFG      = 4'h6,
        CLED_SUPPLY_BAD = 4'h7,
        CLED_LOAD_OFF   = 4'h8,
        CLED_REINT_MAN  = 4'h9,
        CLED_REINT_AUTO = 4'hA,
        CLED_SAFE_ERR   = 4'hB,
        CLED_RUN        = 4'hC
    } cled_mode_t;

endpackage

// >>> cled_decoder.sv
// LED status decoder: modes, blink, LED drive, wishbone registers
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - module or channel fault: fault LEDs red
// - unconfigured: only input status shows input level
// - deactivated channel: input status follows level only
// - channel awaiting reintegration: fault/status alternate 2 Hz
// - manual logic-supply reintegration: reint flashes, channels alternate
// - automatic reintegration: reint flashes, input levels shown
// - supply voltage bad: active output fault LEDs red
// - no active outputs: ignore load supply undervoltage
// - module-detected safety error: only input levels shown
// - identification: status LEDs flash green 0.5 Hz
// - safety address mismatch: output fault LEDs red
// - firmware update: all channel LEDs off
// - revision mismatch: reint red, input levels shown
// - alternating pattern never lights red and green together
// - logic supply off: every LED dark
// - load off, outputs active: fault LEDs red
// - load off, outputs inactive: input levels only
// - both supplies on: supply LEDs green, levels shown
module cled_decoder #(
    parameter int N_IN = cled_pkg::N_IN_CH,
    parameter int N_OUT = cled_pkg::N_OUT_CH,
    parameter int FAST_HALF_CYC = cled_pkg::FAST_HALF_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // wishbone slave
    input wire logic [cled_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic irq_o,
    // supply conditions
    input wire logic logic_supply_on_i,
    input wire logic load_supply_on_i,
    input wire logic logic_supply_oor_i,
    input wire logic load_supply_ov_i,
    input wire logic load_supply_uv_i,
    // module conditions
    input wire logic module_fault_i,
    input wire logic fw_update_i,
    input wire logic rev_mismatch_i,
    input wire logic ident_i,
    input wire logic addr_mismatch_i,
    input wire logic safety_err_module_i,
    input wire logic safety_err_host_i,
    input wire logic reint_logic_man_i,
    input wire logic reint_logic_auto_i,
    // channel conditions
    input wire logic [N_IN-1:0] in_level_i,
    input wire logic [N_IN-1:0] in_fault_i,
    input wire logic [N_IN-1:0] in_reint_i,
    input wire logic [N_OUT-1:0] out_level_i,
    input wire logic [N_OUT-1:0] out_fault_i,
    input wire logic [N_OUT-1:0] out_reint_i,
    // LED drive, high lights the LED
    output logic logic_supply_led_o,
    output logic load_supply_led_o,
    output logic reint_red_o,
    output logic reint_green_o,
    output logic [N_IN-1:0] in_fault_led_o,
    output logic [N_IN-1:0] in_stat_led_o,
    output logic [N_OUT-1:0] out_fault_led_o,
    output logic [N_OUT-1:0] out_stat_led_o
);

    localparam int DIV_W = $clog2(FAST_HALF_CYC + 1);
    localparam int SLOW_W = $clog2(cled_pkg::SLOW_PER_FAST + 1);

    ////////////////////////////////////////////////////////////////////////////
    // blink generator: both rates from one divider
    logic [DIV_W-1:0] div_r;
    logic [SLOW_W-1:0] slow_cnt_r;
    logic fast_r;
    logic slow_r;

    wire tick = (div_r == DIV_W'(FAST_HALF_CYC - 1));
    wire slow_wrap = (slow_cnt_r == SLOW_W'(cled_pkg::SLOW_PER_FAST - 1));

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_r <= '0;
        end else begin
            div_r <= tick ? '0 : div_r + DIV_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fast_r <= 1'b0;
            slow_cnt_r <= '0;
            slow_r <= 1'b0;
        end else if (tick) begin
            fast_r <= ~fast_r;
            slow_cnt_r <= slow_wrap ? '0 : slow_cnt_r + SLOW_W'(1);
            if (slow_wrap) begin
                slow_r <= ~slow_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    logic ctrl_cfg_r;
    logic [N_IN-1:0] in_act_r;
    logic [N_OUT-1:0] out_act_r;
    logic [cled_pkg::EV_W-1:0] irq_stat_r;
    logic [cled_pkg::EV_W-1:0] irq_mask_r;
    logic [cled_pkg::EV_W-1:0] ev_prev_r;
    logic wb_ack_r;
    logic [31:0] wb_dat_r;
    logic irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // mode selection
    wire any_out_act = |out_act_r;
    // with every output off the load supply may be absent or low
    wire load_uv_eff = load_supply_uv_i & any_out_act;
    wire load_missing = ~load_supply_on_i & any_out_act;
    wire supply_bad = logic_supply_oor_i | load_supply_ov_i | load_uv_eff;
    wire reint_auto = reint_logic_auto_i | safety_err_host_i;

    cled_pkg::cled_mode_t mode;
    assign mode = !logic_supply_on_i ? cled_pkg::CLED_OFF :
                  fw_update_i ? cled_pkg::CLED_FW_UPDATE :
                  module_fault_i ? cled_pkg::CLED_MOD_FAULT :
                  rev_mismatch_i ? cled_pkg::CLED_REV_MISM :
                  ident_i ? cled_pkg::CLED_IDENT :
                  addr_mismatch_i ? cled_pkg::CLED_ADDR_MISM :
                  !ctrl_cfg_r ? cled_pkg::CLED_UNCFG :
                  supply_bad ? cled_pkg::CLED_SUPPLY_BAD :
                  load_missing ? cled_pkg::CLED_LOAD_OFF :
                  reint_logic_man_i ? cled_pkg::CLED_REINT_MAN :
                  reint_auto ? cled_pkg::CLED_REINT_AUTO :
                  safety_err_module_i ? cled_pkg::CLED_SAFE_ERR :
                  cled_pkg::CLED_RUN;

    ////////////////////////////////////////////////////////////////////////////
    // per-channel pattern in normal operation
    logic [N_IN-1:0] in_run_fault;
    logic [N_IN-1:0] in_run_stat;
    logic [N_OUT-1:0] out_run_fault;
    logic [N_OUT-1:0] out_run_stat;

    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_in
            wire act = in_act_r[gi];
            wire wait_reint = ~in_fault_i[gi] & in_reint_i[gi];
            // fault and reintegration flash on opposite phases of one toggle
            assign in_run_fault[gi] = act & (in_fault_i[gi] | (wait_reint & fast_r));
            assign in_run_stat[gi] = !act ? in_level_i[gi] :
                                     in_fault_i[gi] ? 1'b0 :
                                     wait_reint ? ~fast_r :
                                     in_level_i[gi];
        end
        for (gi = 0; gi < N_OUT; gi++) begin : g_out
            wire act = out_act_r[gi];
            wire wait_reint = ~out_fault_i[gi] & out_reint_i[gi];
            assign out_run_fault[gi] = act & (out_fault_i[gi] | (wait_reint & fast_r));
            assign out_run_stat[gi] = act & ~out_fault_i[gi] &
                                      (wait_reint ? ~fast_r : out_level_i[gi]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // LED next values
    logic [N_IN-1:0] in_fault_nxt;
    logic [N_IN-1:0] in_stat_nxt;
    logic [N_OUT-1:0] out_fault_nxt;
    logic [N_OUT-1:0] out_stat_nxt;
    logic reint_red_nxt;
    logic reint_green_nxt;

    always_comb begin
        in_fault_nxt = '0;
        in_stat_nxt = '0;
        out_fault_nxt = '0;
        out_stat_nxt = '0;
        reint_red_nxt = 1'b0;
        reint_green_nxt = 1'b0;
        unique case (mode)
            cled_pkg::CLED_OFF: begin
                in_stat_nxt = '0;
            end
            cled_pkg::CLED_FW_UPDATE: begin
                in_stat_nxt = '0;
            end
            cled_pkg::CLED_MOD_FAULT: begin
                in_fault_nxt = '1;
                out_fault_nxt = '1;
            end
            cled_pkg::CLED_REV_MISM: begin
                reint_red_nxt = 1'b1;
                in_stat_nxt = in_level_i;
            end
            cled_pkg::CLED_IDENT: begin
                in_stat_nxt = {N_IN{slow_r}};
                out_stat_nxt = {N_OUT{slow_r}};
            end
            cled_pkg::CLED_ADDR_MISM: begin
                out_fault_nxt = '1;
            end
            cled_pkg::CLED_UNCFG: begin
                in_stat_nxt = in_level_i;
            end
            cled_pkg::CLED_SUPPLY_BAD: begin
                out_fault_nxt = out_act_r;
            end
            cled_pkg::CLED_LOAD_OFF: begin
                in_fault_nxt = '1;
                out_fault_nxt = '1;
            end
            cled_pkg::CLED_REINT_MAN: begin
                reint_red_nxt = fast_r;
                reint_green_nxt = ~fast_r;
                in_fault_nxt = {N_IN{fast_r}};
                in_stat_nxt = {N_IN{~fast_r}};
                out_fault_nxt = {N_OUT{fast_r}};
                out_stat_nxt = {N_OUT{~fast_r}};
            end
            cled_pkg::CLED_REINT_AUTO: begin
                reint_red_nxt = fast_r;
                reint_green_nxt = ~fast_r;
                in_stat_nxt = in_level_i;
            end
            cled_pkg::CLED_SAFE_ERR: begin
                in_stat_nxt = in_level_i;
            end
            cled_pkg::CLED_RUN: begin
                // covers load off with every output deactivated too
                in_fault_nxt = in_run_fault;
                in_stat_nxt = in_run_stat;
                out_fault_nxt = out_run_fault;
                out_stat_nxt = out_run_stat;
            end
        endcase
    end

    wire logic_led_nxt = logic_supply_on_i;
    wire load_led_nxt = logic_supply_on_i & load_supply_on_i;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            in_fault_led_o <= '0;
            in_stat_led_o <= '0;
            out_fault_led_o <= '0;
            out_stat_led_o <= '0;
            reint_red_o <= 1'b0;
            reint_green_o <= 1'b0;
            logic_supply_led_o <= 1'b0;
            load_supply_led_o <= 1'b0;
        end else begin
            in_fault_led_o <= in_fault_nxt;
            in_stat_led_o <= in_stat_nxt;
            out_fault_led_o <= out_fault_nxt;
            out_stat_led_o <= out_stat_nxt;
            reint_red_o <= reint_red_nxt;
            reint_green_o <= reint_green_nxt;
            logic_supply_led_o <= logic_led_nxt;
            load_supply_led_o <= load_led_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wishbone decode; every access is answered in one cycle
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_r;
    // only sel[0] counts; a write lands at the edge where the master sees ack
    wire wb_wr = wb_cyc_i & wb_stb_i & wb_ack_r & wb_we_i & wb_sel_i[0];
    wire sel_ctrl = (wb_adr_i == cled_pkg::CTRL_OFS);
    wire sel_in_act = (wb_adr_i == cled_pkg::IN_ACT_OFS);
    wire sel_out_act = (wb_adr_i == cled_pkg::OUT_ACT_OFS);
    wire sel_status = (wb_adr_i == cled_pkg::STATUS_OFS);
    wire sel_istat = (wb_adr_i == cled_pkg::IRQ_STAT_OFS);
    wire sel_imask = (wb_adr_i == cled_pkg::IRQ_MASK_OFS);
    wire sel_led_in = (wb_adr_i == cled_pkg::LED_IN_OFS);
    wire sel_led_out = (wb_adr_i == cled_pkg::LED_OUT_OFS);

    wire [31:0] status_word = 32'({slow_r, fast_r, mode});
    wire [31:0] led_in_word = 32'({in_stat_led_o, in_fault_led_o});
    wire [31:0] led_out_word = 32'(out_fault_led_o) |
        (32'(out_stat_led_o) << cled_pkg::LED_OUT_STAT_POS) |
        (32'({load_supply_led_o, logic_supply_led_o, reint_green_o, reint_red_o})
            << cled_pkg::LED_OUT_MISC_POS);

    // unmapped addresses read zero and ignore writes
    wire [31:0] rd_mux = sel_ctrl ? 32'(ctrl_cfg_r) :
                         sel_in_act ? 32'(in_act_r) :
                         sel_out_act ? 32'(out_act_r) :
                         sel_status ? status_word :
                         sel_istat ? 32'(irq_stat_r) :
                         sel_imask ? 32'(irq_mask_r) :
                         sel_led_in ? led_in_word :
                         sel_led_out ? led_out_word :
                         32'h0000_0000;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wb_ack_r <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            wb_ack_r <= wb_req;
            wb_dat_r <= wb_req ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_cfg_r <= cled_pkg::CTRL_CFG_RST;
            in_act_r <= N_IN'(cled_pkg::ACT_RST);
            out_act_r <= N_OUT'(cled_pkg::ACT_RST);
            irq_mask_r <= cled_pkg::IRQ_MASK_RST;
        end else if (wb_wr) begin
            if (sel_ctrl) begin
                ctrl_cfg_r <= wb_dat_i[cled_pkg::CTRL_CFG_BIT];
            end
            if (sel_in_act) begin
                in_act_r <= wb_dat_i[N_IN-1:0];
            end
            if (sel_out_act) begin
                out_act_r <= wb_dat_i[N_OUT-1:0];
            end
            if (sel_imask) begin
                irq_mask_r <= wb_dat_i[cled_pkg::EV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt events: rising edge of each condition group
    logic [cled_pkg::EV_W-1:0] ev_cur;
    always_comb begin
        ev_cur = '0;
        ev_cur[cled_pkg::EV_MOD_FAULT] = module_fault_i;
        ev_cur[cled_pkg::EV_REINT] = reint_logic_man_i | reint_auto |
                                     (|in_reint_i) | (|out_reint_i);
        ev_cur[cled_pkg::EV_SUPPLY] = supply_bad | load_missing;
        ev_cur[cled_pkg::EV_SAFETY] = safety_err_module_i | safety_err_host_i;
    end

    wire [cled_pkg::EV_W-1:0] ev_rise = ev_cur & ~ev_prev_r;
    wire [cled_pkg::EV_W-1:0] w1c = (wb_wr & sel_istat) ?
                                    wb_dat_i[cled_pkg::EV_W-1:0] : '0;
    // a new event in the clearing cycle survives the clear
    wire [cled_pkg::EV_W-1:0] irq_stat_nxt = (irq_stat_r & ~w1c) | ev_rise;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ev_prev_r <= '0;
            irq_stat_r <= '0;
            irq_r <= 1'b0;
        end else begin
            ev_prev_r <= ev_cur;
            irq_stat_r <= irq_stat_nxt;
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign wb_ack_o = wb_ack_r;
    assign wb_dat_o = wb_dat_r;
    assign irq_o = irq_r;

endmodule // cled_decoder

// >>> cled_led_model.sv
// model of the reintegration LED
`timescale 1ns/100ps
module cled_led_model (
    input wire logic clk_sys_i,
    input wire logic red_i,
    input wire logic green_i,
    output int toggles_o
);
    logic last_r = 1'h0;
    initial toggles_o = 0;
    // counts each cycle in which red changes or red and green are equal
    always @(posedge clk_sys_i) begin
        if (red_i !== last_r || green_i === red_i) begin
            toggles_o <= toggles_o + 1;
        end
        last_r <= red_i;
    end
endmodule // cled_led_model

// >>> cled_decoder_monitor.sv
// checks on the LED decoder ports
`timescale 1ns/100ps
module cled_decoder_monitor #(
    parameter int N_IN = 8,
    parameter int N_OUT = 3
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic logic_supply_on_i,
    input wire logic load_supply_on_i,
    input wire logic fw_update_i,
    input wire logic module_fault_i,
    input wire logic rev_mismatch_i,
    input wire logic ident_i,
    input wire logic addr_mismatch_i,
    input wire logic [N_IN-1:0] in_level_i,
    input wire logic logic_supply_led_o,
    input wire logic load_supply_led_o,
    input wire logic reint_red_o,
    input wire logic reint_green_o,
    input wire logic [N_IN-1:0] in_fault_led_o,
    input wire logic [N_IN-1:0] in_stat_led_o,
    input wire logic [N_OUT-1:0] out_fault_led_o,
    input wire logic [N_OUT-1:0] out_stat_led_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////////////
    // priority chain of module-wide conditions
    wire lvl1 = logic_supply_on_i && !fw_update_i;
    wire lvl2 = lvl1 && !module_fault_i && !rev_mismatch_i;
    wire no_reint = !reint_red_o && !reint_green_o;
    wire no_fault = (in_fault_led_o == '0) && (out_fault_led_o == '0);
    wire no_stat = (in_stat_led_o == '0) && (out_stat_led_o == '0);

    a_dark_supply_off: assert property (!logic_supply_on_i |=> no_reint && no_fault
        && no_stat && !logic_supply_led_o && !load_supply_led_o) else $error("lit while off");
    a_both_supplies: assert property (logic_supply_on_i && load_supply_on_i |=>
        logic_supply_led_o && load_supply_led_o) else $error("supply LEDs dark");
    a_fw_dark: assert property (logic_supply_on_i && fw_update_i |=> no_reint
        && no_fault && no_stat) else $error("lit during update");
    a_fault_red: assert property (lvl1 && module_fault_i |=> &in_fault_led_o
        && &out_fault_led_o && no_stat && no_reint) else $error("fault LEDs wrong");
    a_rev_red: assert property (lvl1 && !module_fault_i && rev_mismatch_i |=> reint_red_o
        && !reint_green_o && no_fault && in_stat_led_o == $past(in_level_i)) else $error("rev");
    a_ident_blink: assert property (lvl2 && ident_i |=> no_fault && no_reint
        && in_stat_led_o == {N_IN{out_stat_led_o[0]}}
        && out_stat_led_o == {N_OUT{out_stat_led_o[0]}}) else $error("ident pattern");
    a_addr_red: assert property (lvl2 && !ident_i && addr_mismatch_i |=> &out_fault_led_o
        && no_stat && no_reint) else $error("address mismatch");
    a_no_clash: assert property (((in_fault_led_o & in_stat_led_o) == '0)
        && ((out_fault_led_o & out_stat_led_o) == '0)) else $error("red and green together");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
endmodule // cled_decoder_monitor

// >>> cled_decoder_bench.sv
// bench for the LED decoder
`timescale 1ns/100ps
module cled_decoder_bench;
    localparam int FHC = 8;
    logic clk_sys_i = 1'h0, rst_b_i = 1'h0, wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [3:0] wb_sel_i = 4'hF;
    logic logic_supply_on_i = 1'h1, load_supply_on_i = 1'h1, logic_supply_oor_i = 1'h0;
    logic load_supply_ov_i = 1'h0, load_supply_uv_i = 1'h0, module_fault_i = 1'h0;
    logic fw_update_i = 1'h0, rev_mismatch_i = 1'h0, ident_i = 1'h0, addr_mismatch_i = 1'h0;
    logic safety_err_module_i = 1'h0, safety_err_host_i = 1'h0;
    logic reint_logic_man_i = 1'h0, reint_logic_auto_i = 1'h0;
    logic [7:0] in_level_i = 8'hA5, in_fault_i = 8'h00, in_reint_i = 8'h00;
    logic [2:0] out_level_i = 3'h5, out_fault_i = 3'h0, out_reint_i = 3'h0;
    logic wb_ack_o, irq_o, logic_supply_led_o, load_supply_led_o, reint_red_o, reint_green_o, f;
    logic [7:0] in_fault_led_o, in_stat_led_o;
    logic [2:0] out_fault_led_o, out_stat_led_o;
    int failures = 0, n_tests = 0, toggles, t0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    cled_decoder #(.FAST_HALF_CYC(FHC)) i_cled_decoder (
        .clk_sys_i, .rst_b_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i, .wb_cyc_i,
        .wb_stb_i, .wb_ack_o, .irq_o, .logic_supply_on_i, .load_supply_on_i, .logic_supply_oor_i,
        .load_supply_ov_i, .load_supply_uv_i, .module_fault_i, .fw_update_i, .rev_mismatch_i,
        .ident_i, .addr_mismatch_i, .safety_err_module_i, .safety_err_host_i, .reint_logic_man_i,
        .reint_logic_auto_i, .in_level_i, .in_fault_i, .in_reint_i, .out_level_i, .out_fault_i,
        .out_reint_i, .logic_supply_led_o, .load_supply_led_o, .reint_red_o, .reint_green_o,
        .in_fault_led_o, .in_stat_led_o, .out_fault_led_o, .out_stat_led_o);
    cled_led_model i_cled_led_model (.clk_sys_i, .red_i(reint_red_o), .green_i(reint_green_o),
        .toggles_o(toggles));
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic led(input logic [7:0] inf, ins, input logic [2:0] of, os,
                       input logic [1:0] rr, sp);
        chk({6'h0, logic_supply_led_o, load_supply_led_o, reint_red_o, reint_green_o,
            out_stat_led_o, out_fault_led_o, in_stat_led_o, in_fault_led_o},
            {6'h0, sp, rr, os, of, ins, inf});
    endtask
    task automatic alt(input logic r);
        tick(2);
        f = in_fault_led_o[0];
        repeat (2) begin
            led({8{f}}, {8{~f}}, {3{f}}, {3{~f}}, {r & f, r & ~f}, 2'h3);
            tick(FHC);
            f = ~f;
        end
    endtask
    // a mute slave is reported, not hung on
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        chk(32'(n < 20), 32'h1);
    endtask
    task automatic cond(input logic [8:0] c);
        @(posedge clk_sys_i);
        {reint_logic_man_i, reint_logic_auto_i, safety_err_host_i, safety_err_module_i,
            addr_mismatch_i, ident_i, rev_mismatch_i, module_fault_i, fw_update_i} <= c;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_sys_i);
        rst_b_i <= 1'h1;
        tick(2);
        led(8'h00, 8'hA5, 3'h0, 3'h0, 2'h0, 2'h3);
        wb(1'h0, cled_pkg::CTRL_OFS, 32'h0);
        chk(q, 32'h0);
        wb(1'h1, 8'h20, 32'hFFFF_FFFF);
        wb(1'h0, 8'h20, 32'h0);
        chk(q, 32'h0);
        wb(1'h1, cled_pkg::CTRL_OFS, 32'h1);
        wb(1'h1, cled_pkg::IN_ACT_OFS, 32'h0F);
        wb(1'h1, cled_pkg::OUT_ACT_OFS, 32'h6);
        in_fault_i <= 8'h11;
        out_fault_i <= 3'h3;
        tick(2);
        led(8'h01, 8'hA4, 3'h2, 3'h4, 2'h0, 2'h3);
        wb(1'h1, cled_pkg::IN_ACT_OFS, 32'hFF);
        wb(1'h1, cled_pkg::OUT_ACT_OFS, 32'h7);
        {in_fault_i, out_fault_i} <= 11'h0;
        tick(2);
        led(8'h00, 8'hA5, 3'h0, 3'h5, 2'h0, 2'h3);
        wb(1'h0, cled_pkg::STATUS_OFS, 32'h0);
        chk(32'(q[3:0]), 32'(cled_pkg::CLED_RUN));
        {in_reint_i, out_reint_i} <= 11'h7FF;
        alt(1'h0);
        cond(9'h100);
        {in_reint_i, out_reint_i} <= 11'h0;
        alt(1'h1);
        cond(9'h008);
        tick(2);
        f = in_stat_led_o[0];
        repeat (2) begin
            led(8'h00, {8{f}}, 3'h0, {3{f}}, 2'h0, 2'h3);
            tick(4 * FHC);
            f = ~f;
        end
        for (int i = 0; i < 8; i++) begin
            cond(9'(1 << i));
            tick(2);
            f = (i == 3) ? in_stat_led_o[0] : reint_red_o;
            t0 = toggles;
            case (i)
                0: led(8'h00, 8'h00, 3'h0, 3'h0, 2'h0, 2'h3);
                1: led(8'hFF, 8'h00, 3'h7, 3'h0, 2'h0, 2'h3);
                2: led(8'h00, 8'hA5, 3'h0, 3'h0, 2'h2, 2'h3);
                3: led(8'h00, {8{f}}, 3'h0, {3{f}}, 2'h0, 2'h3);
                4: led(8'h00, 8'h00, 3'h7, 3'h0, 2'h0, 2'h3);
                5: led(8'h00, 8'hA5, 3'h0, 3'h0, 2'h0, 2'h3);
                default: led(8'h00, 8'hA5, 3'h0, 3'h0, {f, ~f}, 2'h3);
            endcase
            tick(FHC);
            if (i > 5) chk(32'(toggles - t0), 32'h1);
        end
        cond(9'h0);
        logic_supply_oor_i <= 1'h1;
        tick(2);
        led(8'h00, 8'h00, 3'h7, 3'h0, 2'h0, 2'h3);
        wb(1'h1, cled_pkg::OUT_ACT_OFS, 32'h0);
        logic_supply_oor_i <= 1'h0;
        load_supply_uv_i <= 1'h1;
        tick(2);
        led(8'h00, 8'hA5, 3'h0, 3'h0, 2'h0, 2'h3);
        @(posedge clk_sys_i);
        {load_supply_on_i, load_supply_uv_i} <= 2'h0;
        tick(2);
        led(8'h00, 8'hA5, 3'h0, 3'h0, 2'h0, 2'h2);
        wb(1'h1, cled_pkg::OUT_ACT_OFS, 32'h7);
        tick(2);
        led(8'hFF, 8'h00, 3'h7, 3'h0, 2'h0, 2'h2);
        @(posedge clk_sys_i);
        logic_supply_on_i <= 1'h0;
        tick(2);
        led(8'h00, 8'h00, 3'h0, 3'h0, 2'h0, 2'h0);
        @(posedge clk_sys_i);
        {logic_supply_on_i, load_supply_on_i} <= 2'h3;
        tick(2);
        chk(32'(irq_o), 32'h0);
        wb(1'h1, cled_pkg::IRQ_MASK_OFS, 32'h1);
        tick(2);
        chk(32'(irq_o), 32'h1);
        wb(1'h0, cled_pkg::IRQ_STAT_OFS, 32'h0);
        chk(32'(q[0]), 32'h1);
        wb(1'h1, cled_pkg::IRQ_STAT_OFS, 32'h1);
        tick(2);
        chk(32'(irq_o), 32'h0);
        end_of_test();
    end
    initial begin
        #100000;
        failures++;
        $display("ERROR %0t: timeout", $time);
        end_of_test();
    end
endmodule // cled_decoder_bench

bind cled_decoder cled_decoder_monitor #(.N_IN(N_IN), .N_OUT(N_OUT)) i_cled_decoder_monitor (
    .clk_sys_i, .rst_b_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .logic_supply_on_i,
    .load_supply_on_i, .fw_update_i, .module_fault_i, .rev_mismatch_i, .ident_i,
    .addr_mismatch_i, .in_level_i, .logic_supply_led_o, .load_supply_led_o, .reint_red_o,
    .reint_green_o, .in_fault_led_o, .in_stat_led_o, .out_fault_led_o, .out_stat_led_o);
